// ### hdl/slc_pkg.sv
// Package: register map, field layout and reset values of the link channel config
//
// Behaviour
// [R1] Software writes zero to reserved bits
// [R2] Single-channel select disables channels B, C, D
// [R3] Upper-pair enable gates channels C and D
// [R4] Lower-pair enable gates channels A and B
// [R5] Calibration and link disabled before channel changes
// [R6] Never disable all channels via enables
// [R7] One pair off halves converters, lanes ceil-halved
// [R8] Odd lanes, one pair off: pad tail bits
// [R9] Lower pair off: C,D take A,B slots
// [R10] Header select: 0 CRC-12, 2 FEC, 64b/66b only
// [R11] Command fields always zero, idle headers
// [R12] Header and threshold changed only link-disabled
// [R13] Sync request input sampled on link clock
// [R14] Request after threshold-plus-one consecutive low samples
// [R15] Shorter low pulses are error reports, ignored
// [R16] Receiver disables error reports, threshold zero
package slc_pkg;
	// Device register indexes and byte addresses (index * 4 on the bus)
	localparam logic [11:0] CHAN_EN_IDX   = 12'h0209;
	localparam logic [11:0] SYNC_HDR_IDX  = 12'h020f;
	localparam logic [11:0] SYNC_THR_IDX  = 12'h0210;
	localparam logic [13:0] CHAN_EN_ADDR  = {CHAN_EN_IDX, 2'b00};
	localparam logic [13:0] SYNC_HDR_ADDR = {SYNC_HDR_IDX, 2'b00};
	localparam logic [13:0] SYNC_THR_ADDR = {SYNC_THR_IDX, 2'b00};
	// Controller's own registers
	localparam logic [13:0] CTRL_ADDR     = 14'h0000;
	localparam logic [13:0] STAT_ADDR     = 14'h0004;
	localparam logic [13:0] MODE_ADDR     = 14'h0008;
	// Field positions
	localparam int LOWER_BIT  = 0;
	localparam int UPPER_BIT  = 1;
	localparam int SINGLE_BIT = 2;
	localparam int LINK_EN_BIT = 0;
	localparam int CAL_EN_BIT  = 1;
	localparam int MODE_6466_BIT = 0;
	// Reset values
	localparam logic [7:0] CHAN_EN_RST  = 8'h03;
	localparam logic [7:0] SYNC_HDR_RST = 8'h00;
	localparam logic [7:0] SYNC_THR_RST = 8'h03;
	localparam logic [7:0] CHAN_EN_MASK  = 8'h07;
	localparam logic [7:0] SYNC_HDR_MASK = 8'h03;
	localparam logic [7:0] SYNC_THR_MASK = 8'h1f;
	localparam logic [1:0] HDR_CRC12 = 2'h0;
	localparam logic [1:0] HDR_FEC   = 2'h2;
	localparam logic [1:0] RESP_OKAY   = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;
	localparam logic [1:0] RESP_DECERR = 2'b11;
	// Link clock is the core clock halved
	localparam int LINK_DIV = 2;
	typedef enum logic [1:0] {HDR_SEND_CRC, HDR_SEND_FEC, HDR_SEND_NONE}
		slc_hdr_e;
endpackage

// ### hdl/slc_if.sv
// Interface joining the register port, the link config and the sync pin
`timescale 1ns/1ps
interface slc_if;
	logic        wr_stb;
	logic        rd_stb;
	logic [11:0] reg_idx;
	logic [7:0]  wr_data;
	logic [7:0]  rd_data;
	logic        rd_valid;
	logic        sync_n;
	modport device (
		input  wr_stb, rd_stb, reg_idx, wr_data, sync_n,
		output rd_data, rd_valid
	);
	modport host (
		output wr_stb, rd_stb, reg_idx, wr_data, sync_n,
		input  rd_data, rd_valid
	);
endinterface

// ### hdl/slc_device.sv
// Device end: channel enables, link scaling, sync header, sync filter
`timescale 1ns/1ps
module slc_device
	import slc_pkg::*;
#(
	parameter int LANES_CFG = 8,
	parameter int CONV_CFG  = 4
)(
	input  wire logic       core_clk,
	input  wire logic       reset,
	slc_if.device           bus,
	input  wire logic       link_enable,
	input  wire logic       link_mode_6466,
	output logic [3:0]      channel_active,
	output logic [3:0]      lane_count,
	output logic [3:0]      converter_count,
	output logic            tail_pad,
	output logic            upper_in_lower_slots,
	output logic [1:0]      header_kind,
	output logic [7:0]      header_cmd,
	output logic            sync_request
);
	// Counts must fit four bits and the halved converter count stay nonzero
	if (LANES_CFG < 1 || LANES_CFG > 8 || CONV_CFG < 2 || CONV_CFG > 8)
	begin : g_cfg_bad
		$error("slc_device: unsupported lane or converter count");
	end

	typedef struct packed {
		logic [7:0] chan_en;
		logic [7:0] hdr_sel;
		logic [7:0] thr;
		logic [7:0] rd_data;
		logic       rd_valid;
		logic       div;
		logic [2:0] sync_sh;
		logic [5:0] low_cnt;
		logic       req;
	} slc_dev_s;

	slc_dev_s s_q;
	slc_dev_s s_d;
	logic     one_off;

	always_comb
	begin
		s_d = s_q;
		s_d.rd_valid = 1'b0;
		if (bus.wr_stb)
		begin
			// Reserved bits are masked so they always read back as zero
			case (bus.reg_idx) // R1
				CHAN_EN_IDX:  s_d.chan_en = bus.wr_data & CHAN_EN_MASK;
				SYNC_HDR_IDX: s_d.hdr_sel = bus.wr_data & SYNC_HDR_MASK;
				SYNC_THR_IDX: s_d.thr     = bus.wr_data & SYNC_THR_MASK;
				default:      ;
			endcase
		end
		if (bus.rd_stb)
		begin
			s_d.rd_valid = 1'b1;
			case (bus.reg_idx)
				CHAN_EN_IDX:  s_d.rd_data = s_q.chan_en;
				SYNC_HDR_IDX: s_d.rd_data = s_q.hdr_sel;
				SYNC_THR_IDX: s_d.rd_data = s_q.thr;
				default:      s_d.rd_data = 8'h00;
			endcase
		end
		// Link clock runs at half the core rate
		s_d.div = ~s_q.div; // R13
		s_d.sync_sh = {s_q.sync_sh[1:0], bus.sync_n};
		if (s_q.div)
		begin
			// Only a settled, agreeing low level counts as a sample
			if (s_q.sync_sh[2] == s_q.sync_sh[1] && !s_q.sync_sh[2]) // R13
			begin
				if (s_q.low_cnt <= {1'b0, s_q.thr[4:0]})
					s_d.low_cnt = s_q.low_cnt + 6'd1;
				if (s_q.low_cnt >= {1'b0, s_q.thr[4:0]}) // R14
					s_d.req = link_enable;
			end
			else
			begin
				// Short lows end here with no action taken
				s_d.low_cnt = 6'd0; // R15
				s_d.req     = 1'b0;
			end
		end
		if (!link_enable)
		begin
			s_d.low_cnt = 6'd0;
			s_d.req     = 1'b0;
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (reset)
		begin
			s_q <= '0;
			s_q.chan_en <= CHAN_EN_RST; // R3 R4
			s_q.hdr_sel <= SYNC_HDR_RST;
			s_q.thr     <= SYNC_THR_RST; // R14
			s_q.sync_sh <= 3'b111;
		end
		else
			s_q <= s_d;
	end

	assign bus.rd_data  = s_q.rd_data;
	assign bus.rd_valid = s_q.rd_valid;

	always_comb
	begin
		if (s_q.chan_en[SINGLE_BIT])
			channel_active = 4'b0001; // R2
		else
			channel_active = {{2{s_q.chan_en[UPPER_BIT]}},
				{2{s_q.chan_en[LOWER_BIT]}}}; // R3 R4
	end

	assign one_off = !(s_q.chan_en[UPPER_BIT] && s_q.chan_en[LOWER_BIT]);
	assign lane_count = one_off ? 4'((LANES_CFG + 1) / 2) // R7
		: 4'(LANES_CFG);
	assign converter_count = one_off ? 4'(CONV_CFG / 2) : 4'(CONV_CFG); // R7
	assign tail_pad = one_off && (LANES_CFG % 2 == 1); // R8
	assign upper_in_lower_slots = !s_q.chan_en[LOWER_BIT]; // R9

	always_comb
	begin
		header_kind = HDR_SEND_NONE;
		if (link_mode_6466) // R10
		begin
			case (s_q.hdr_sel[1:0])
				HDR_CRC12: header_kind = HDR_SEND_CRC;
				HDR_FEC:   header_kind = HDR_SEND_FEC;
				default:   header_kind = HDR_SEND_NONE;
			endcase
		end
	end
	assign header_cmd   = 8'h00; // R11
	assign sync_request = s_q.req;
endmodule // slc_device

// ### hdl/slc_host.sv
// Host end: AXI4-Lite slave bridging to the device registers and sync pin
//
// Register access over AXI4-Lite was chosen for this implementation.
`timescale 1ns/1ps
module slc_host
	import slc_pkg::*;
(
	input  wire logic        core_clk,
	input  wire logic        reset,
	slc_if.host              dev,
	input  wire logic [13:0] s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [13:0] s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic        sync_n_in,
	output logic             link_enable,
	output logic             cal_enable,
	output logic             link_mode_6466
);
	typedef enum logic [1:0] {RD_IDLE, RD_WAIT, RD_RESP} slc_rd_e;
	typedef struct packed {
		logic        aw_got;
		logic [13:0] aw;
		logic        w_got;
		logic [7:0]  wd;
		logic        wlane;
		logic        bvalid;
		logic [1:0]  bresp;
		slc_rd_e     rd;
		logic [13:0] ar;
		logic [31:0] rdata;
		logic [1:0]  rresp;
		logic [7:0]  ctrl;
		logic [7:0]  mode;
		logic        wr_stb;
		logic        rd_stb;
		logic [11:0] idx;
		logic [7:0]  dwd;
		logic        cfg_err;
		logic [2:0]  pin_sh;
		logic        pin_lvl;
	} slc_host_s;

	slc_host_s s_q;
	slc_host_s s_d;
	logic      wr_fire;

	// Reads and writes share the device index, so a read waits out a write
	assign wr_fire = s_q.aw_got && s_q.w_got && !s_q.bvalid;

	function automatic logic is_dev(input logic [13:0] a);
		return a == CHAN_EN_ADDR || a == SYNC_HDR_ADDR || a == SYNC_THR_ADDR;
	endfunction

	always_comb
	begin
		s_d = s_q;
		s_d.wr_stb = 1'b0;
		s_d.rd_stb = 1'b0;
		if (s_axi_awvalid && !s_q.aw_got)
		begin
			s_d.aw_got = 1'b1;
			s_d.aw = s_axi_awaddr;
		end
		if (s_axi_wvalid && !s_q.w_got)
		begin
			s_d.w_got = 1'b1;
			s_d.wd = s_axi_wdata[7:0];
			s_d.wlane = s_axi_wstrb[0];
		end
		if (wr_fire)
		begin
			s_d.aw_got = 1'b0;
			s_d.w_got  = 1'b0;
			s_d.bvalid = 1'b1;
			s_d.bresp  = RESP_OKAY;
			if (is_dev(s_q.aw))
			begin
				// Channel enables need calibration and link off first
				if ((s_q.aw == CHAN_EN_ADDR && // R5
					(s_q.ctrl[LINK_EN_BIT] || s_q.ctrl[CAL_EN_BIT]))
					|| s_q.ctrl[LINK_EN_BIT] // R12
					|| (s_q.aw == CHAN_EN_ADDR && // R6
					s_q.wd[2:0] == 3'b000)
					|| (s_q.aw == CHAN_EN_ADDR && s_q.wd[SINGLE_BIT]
					&& !s_q.wd[LOWER_BIT])) // R2
				begin
					s_d.bresp   = RESP_SLVERR;
					s_d.cfg_err = 1'b1;
				end
				else if (s_q.wlane)
				begin
					s_d.wr_stb = 1'b1;
					s_d.idx = s_q.aw[13:2];
					s_d.dwd = s_q.wd & ((s_q.aw == CHAN_EN_ADDR) ? // R1
						CHAN_EN_MASK : (s_q.aw == SYNC_HDR_ADDR) ?
						SYNC_HDR_MASK : SYNC_THR_MASK);
				end
			end
			else if (s_q.aw == CTRL_ADDR)
			begin
				if (s_q.wlane)
					s_d.ctrl = s_q.wd & 8'h03;
			end
			else if (s_q.aw == MODE_ADDR)
			begin
				if (s_q.wlane)
					s_d.mode = s_q.wd & 8'h01;
			end
			else if (s_q.aw == STAT_ADDR)
			begin
				if (s_q.wlane && s_q.wd[1])
					s_d.cfg_err = 1'b0;
			end
			else
				s_d.bresp = RESP_DECERR;
		end
		if (s_q.bvalid && s_axi_bready)
			s_d.bvalid = 1'b0;
		// Status shows the pin only once two synchroniser stages agree
		s_d.pin_sh = {s_q.pin_sh[1:0], sync_n_in};
		if (s_q.pin_sh[2] == s_q.pin_sh[1])
			s_d.pin_lvl = s_q.pin_sh[2];
		case (s_q.rd)
			RD_IDLE:
			begin
				if (s_axi_arvalid && !wr_fire)
				begin
					s_d.ar = s_axi_araddr;
					s_d.rresp = RESP_OKAY;
					s_d.rdata = 32'h0000_0000;
					if (is_dev(s_axi_araddr))
					begin
						s_d.rd_stb = 1'b1;
						s_d.idx = s_axi_araddr[13:2];
						s_d.rd = RD_WAIT;
					end
					else
					begin
						s_d.rd = RD_RESP;
						case (s_axi_araddr)
							CTRL_ADDR: s_d.rdata = {24'h0, s_q.ctrl};
							MODE_ADDR: s_d.rdata = {24'h0, s_q.mode};
							STAT_ADDR: s_d.rdata = {30'h0, s_q.cfg_err,
								s_q.pin_lvl};
							default:   s_d.rresp = RESP_DECERR;
						endcase
					end
				end
			end
			RD_WAIT:
			begin
				if (dev.rd_valid)
				begin
					s_d.rdata = {24'h0, dev.rd_data};
					s_d.rd = RD_RESP;
				end
			end
			RD_RESP:
			begin
				if (s_axi_rready)
					s_d.rd = RD_IDLE;
			end
			default: s_d.rd = RD_IDLE;
		endcase
	end

	always_ff @(posedge core_clk)
	begin
		if (reset)
		begin
			s_q         <= '0;
			// Idle pin level, so no false change follows reset
			s_q.pin_sh  <= 3'b111;
			s_q.pin_lvl <= 1'b1;
		end
		else
			s_q <= s_d;
	end

	assign s_axi_awready = !s_q.aw_got;
	assign s_axi_wready  = !s_q.w_got;
	assign s_axi_bvalid  = s_q.bvalid;
	assign s_axi_bresp   = s_q.bresp;
	assign s_axi_arready = s_q.rd == RD_IDLE && !wr_fire;
	assign s_axi_rvalid  = s_q.rd == RD_RESP;
	assign s_axi_rdata   = s_q.rdata;
	assign s_axi_rresp   = s_q.rresp;
	assign dev.wr_stb    = s_q.wr_stb;
	assign dev.rd_stb    = s_q.rd_stb;
	assign dev.reg_idx   = s_q.idx;
	assign dev.wr_data   = s_q.dwd;
	assign dev.sync_n    = sync_n_in;
	assign link_enable   = s_q.ctrl[LINK_EN_BIT];
	assign cal_enable    = s_q.ctrl[CAL_EN_BIT];
	assign link_mode_6466 = s_q.mode[MODE_6466_BIT];
endmodule // slc_host

// ### tb/slc_chk.sv
// Checker for the link config interface and the device outputs
`timescale 1ns/1ps
module slc_chk
	import slc_pkg::*;
#(
	parameter int LANES_CFG = 8,
	parameter int CONV_CFG  = 4
)(
	input wire logic        core_clk,
	input wire logic        reset,
	input wire logic        wr_stb,
	input wire logic        rd_stb,
	input wire logic [11:0] reg_idx,
	input wire logic [7:0]  wr_data,
	input wire logic        rd_valid,
	input wire logic        sync_n,
	input wire logic        link_mode_6466,
	input wire logic [3:0]  channel_active,
	input wire logic [3:0]  lane_count,
	input wire logic [3:0]  converter_count,
	input wire logic        tail_pad,
	input wire logic        upper_in_lower_slots,
	input wire logic [1:0]  header_kind,
	input wire logic [7:0]  header_cmd,
	input wire logic        sync_request
);
	typedef struct packed {
		logic [2:0] ch;
		logic [1:0] hdr;
		logic [4:0] thr;
		logic [5:0] low;
		logic [3:0] high;
		logic       ok;
	} slc_mirror_s;
	slc_mirror_s m_q, m_d;
	// Mirror of accepted writes; ok marks a low run long enough
	always_comb
	begin
		m_d = m_q;
		if (wr_stb && reg_idx == CHAN_EN_IDX) m_d.ch = wr_data[2:0];
		if (wr_stb && reg_idx == SYNC_HDR_IDX) m_d.hdr = wr_data[1:0];
		if (wr_stb && reg_idx == SYNC_THR_IDX) m_d.thr = wr_data[4:0];
		m_d.low = sync_n ? 6'h0 : m_q.low + {5'h0, m_q.low != 6'h3f};
		m_d.high = !sync_n ? 4'h0 : m_q.high + {3'h0, m_q.high != 4'hf};
		if (m_d.low >= {m_q.thr, 1'h1}) m_d.ok = 1'h1;
		// Cleared only well after the synchroniser has seen the high
		if (m_q.high > 4'h8) m_d.ok = 1'h0;
	end
	always_ff @(posedge core_clk)
		m_q <= reset ? {3'h3, 2'h0, 5'h03, 6'h00, 4'h0, 1'h0} : m_d;
	default clocking @(posedge core_clk); endclocking
	default disable iff (reset);
	chk_rd_answer: assert property (rd_stb |=> rd_valid)
		else $error("read answer missing");
	chk_rd_cause: assert property (rd_valid |-> $past(rd_stb))
		else $error("read answer without request");
	chk_cmd_idle: assert property (header_cmd == 8'h00)
		else $error("command field not idle");
	chk_single_mode: assert property (m_q.ch[2] |->
		channel_active == 4'h1) else $error("single mode wrong");
	chk_pair_gates: assert property (!m_q.ch[2] |->
		channel_active == {{2{m_q.ch[1]}}, {2{m_q.ch[0]}}})
		else $error("pair enables wrong");
	chk_lane_scale: assert property (!m_q.ch[2] &&
		m_q.ch[1:0] != 2'h3 |-> lane_count == 4'((LANES_CFG + 1) / 2)
		&& converter_count == 4'(CONV_CFG / 2)) else $error("scaling");
	chk_tail_pad: assert property (!m_q.ch[2] |-> tail_pad ==
		(m_q.ch[1:0] != 2'h3 && LANES_CFG % 2 == 1))
		else $error("tail pad wrong");
	chk_slot_swap: assert property (!m_q.ch[2] |->
		upper_in_lower_slots == (m_q.ch[1:0] == 2'h2))
		else $error("slot swap wrong");
	chk_hdr_kind: assert property (!m_q.hdr[0] |-> header_kind ==
		(link_mode_6466 ? {1'h0, m_q.hdr[1]} : 2'h2))
		else $error("header kind wrong");
	chk_sync_filter: assert property ($rose(sync_request) |->
		m_q.ok) else $error("request from short low");
	cov_request: cover property ($rose(sync_request));
	cov_single: cover property (m_q.ch == 3'h5);
	cov_fec: cover property (header_kind == 2'h1);
endmodule // slc_chk

// ### tb/serial_link_channel_sync_config_test.sv
// Bench driving both ends over AXI4-Lite and the sync pin
`timescale 1ns/1ps
module serial_link_channel_sync_config_test
	import slc_pkg::*;
;
	localparam int LN = 7;
	localparam int CV = 4;
	logic        core_clk = 1'h0;
	logic        reset = 1'h1;
	logic [13:0] awaddr = 14'h0, araddr = 14'h0;
	logic [31:0] wdata = 32'h0, rdata;
	logic        awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
	logic        arvalid = 1'h0, rready = 1'h0, sync_pin = 1'h1;
	logic        awready, wready, bvalid, arready, rvalid;
	logic [1:0]  bresp, rresp, hkind;
	logic        link_en, cal_en, mode64, tail, swap, sreq;
	logic [3:0]  act, lanes, convs;
	logic [7:0]  hcmd;
	int          error_cnt = 0;
	int          n_checks = 0;
	slc_if bus_if ();
	slc_host u_slc_host (.core_clk(core_clk), .reset(reset),
		.dev(bus_if), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready), .sync_n_in(sync_pin),
		.link_enable(link_en), .cal_enable(cal_en), .link_mode_6466(mode64));
	slc_device #(.LANES_CFG(LN), .CONV_CFG(CV)) u_slc_device (
		.core_clk(core_clk), .reset(reset), .bus(bus_if),
		.link_enable(link_en), .link_mode_6466(mode64),
		.channel_active(act), .lane_count(lanes), .converter_count(convs),
		.tail_pad(tail), .upper_in_lower_slots(swap), .header_kind(hkind),
		.header_cmd(hcmd), .sync_request(sreq));
	slc_chk #(.LANES_CFG(LN), .CONV_CFG(CV)) u_slc_chk (
		.core_clk(core_clk), .reset(reset), .wr_stb(bus_if.wr_stb),
		.rd_stb(bus_if.rd_stb), .reg_idx(bus_if.reg_idx),
		.wr_data(bus_if.wr_data), .rd_valid(bus_if.rd_valid),
		.sync_n(bus_if.sync_n), .link_mode_6466(mode64),
		.channel_active(act), .lane_count(lanes), .converter_count(convs),
		.tail_pad(tail), .upper_in_lower_slots(swap), .header_kind(hkind),
		.header_cmd(hcmd), .sync_request(sreq));
	always #12.5 core_clk = ~core_clk;
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic wrap_up;
		$display("checks=%0d mismatches=%0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic guard(input int i);
		if (i >= 50)
		begin
			check(32'(i), 32'h0);
			wrap_up;
		end
	endtask
	// Response wait is bounded to 50 cycles; guard ends the run if no response comes
	task automatic axi_wr(input logic [13:0] a, input logic [7:0] d,
		input logic [1:0] er);
		int i;
		@(posedge core_clk);
		awaddr <= a;
		wdata <= 32'(d);
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		bready <= 1'h1;
		for (i = 0; i < 50; i++)
		begin
			@(posedge core_clk);
			if (awready) awvalid <= 1'h0;
			if (wready) wvalid <= 1'h0;
			if (bvalid) break;
		end
		bready <= 1'h0;
		guard(i);
		check(bresp, er);
	endtask
	task automatic axi_rd(input logic [13:0] a, input logic [7:0] d,
		input logic [1:0] er);
		int i;
		@(posedge core_clk);
		araddr <= a;
		arvalid <= 1'h1;
		rready <= 1'h1;
		for (i = 0; i < 50; i++)
		begin
			@(posedge core_clk);
			if (arready) arvalid <= 1'h0;
			if (rvalid) break;
		end
		rready <= 1'h0;
		guard(i);
		check(rresp, er);
		if (er == RESP_OKAY) check(rdata, 32'(d));
	endtask
	// Low for n core cycles, then high long enough for the filter to clear
	task automatic pulse(input int n, output logic s);
		s = 1'h0;
		sync_pin <= 1'h0;
		repeat (n + 16)
		begin
			@(posedge core_clk);
			s |= sreq;
			if (--n == 0) sync_pin <= 1'h1;
		end
	endtask
	task automatic one_ch(input logic [2:0] v);
		logic h;
		h = !v[2] && v[1:0] != 2'h3;
		axi_wr(CHAN_EN_ADDR, 8'(v), RESP_OKAY);
		axi_rd(CHAN_EN_ADDR, 8'(v), RESP_OKAY);
		check(act, v[2] ? 4'h1 : {{2{v[1]}}, {2{v[0]}}});
		if (!v[2])
		begin
			check(lanes, h ? 4'((LN + 1) / 2) : 4'(LN));
			check(convs, h ? 4'(CV / 2) : 4'(CV));
			check(tail, h);
			check(swap, v[1:0] == 2'h2);
		end
	endtask
	task automatic t_regs;
		axi_rd(CHAN_EN_ADDR, CHAN_EN_RST, RESP_OKAY);
		axi_rd(SYNC_HDR_ADDR, SYNC_HDR_RST, RESP_OKAY);
		axi_rd(SYNC_THR_ADDR, SYNC_THR_RST, RESP_OKAY);
		one_ch(3'h1);
		one_ch(3'h2);
		one_ch(3'h5);
		one_ch(3'h3);
		$display("registers and channel pairs done");
	endtask
	task automatic t_refuse;
		axi_wr(CTRL_ADDR, 8'h02, RESP_OKAY);
		check({link_en, cal_en}, 2'h1);
		axi_wr(CHAN_EN_ADDR, 8'h01, RESP_SLVERR);
		axi_wr(CTRL_ADDR, 8'h01, RESP_OKAY);
		check({link_en, cal_en}, 2'h2);
		axi_wr(CHAN_EN_ADDR, 8'h01, RESP_SLVERR);
		axi_wr(SYNC_THR_ADDR, 8'h00, RESP_SLVERR);
		axi_wr(SYNC_HDR_ADDR, 8'h02, RESP_SLVERR);
		axi_wr(CTRL_ADDR, 8'h00, RESP_OKAY);
		axi_wr(CHAN_EN_ADDR, 8'h00, RESP_SLVERR);
		axi_wr(CHAN_EN_ADDR, 8'h04, RESP_SLVERR);
		axi_rd(CHAN_EN_ADDR, 8'h03, RESP_OKAY);
		axi_rd(SYNC_THR_ADDR, 8'h03, RESP_OKAY);
		// Refusals left the sticky error set; the idle pin reads high
		axi_rd(STAT_ADDR, 8'h03, RESP_OKAY);
		axi_wr(STAT_ADDR, 8'h02, RESP_OKAY);
		axi_rd(STAT_ADDR, 8'h01, RESP_OKAY);
		axi_wr(14'h0100, 8'h00, RESP_DECERR);
		axi_rd(14'h0100, 8'h00, RESP_DECERR);
		$display("refusals done");
	endtask
	task automatic t_hdr;
		axi_wr(MODE_ADDR, 8'h01, RESP_OKAY);
		check(mode64, 1'h1);
		axi_wr(SYNC_HDR_ADDR, 8'(HDR_FEC), RESP_OKAY);
		axi_rd(SYNC_HDR_ADDR, 8'(HDR_FEC), RESP_OKAY);
		check(hkind, 2'h1);
		axi_wr(SYNC_HDR_ADDR, 8'h01, RESP_OKAY);
		axi_rd(SYNC_HDR_ADDR, 8'h01, RESP_OKAY);
		check(hkind, 2'h2);
		axi_wr(SYNC_HDR_ADDR, 8'(HDR_CRC12), RESP_OKAY);
		axi_rd(SYNC_HDR_ADDR, 8'(HDR_CRC12), RESP_OKAY);
		check(hkind, 2'h0);
		axi_wr(MODE_ADDR, 8'h00, RESP_OKAY);
		axi_rd(MODE_ADDR, 8'h00, RESP_OKAY);
		check(hkind, 2'h2);
		check(hcmd, 8'h00);
		$display("sync header done");
	endtask
	task automatic t_sync;
		logic s;
		axi_wr(CTRL_ADDR, 8'h01, RESP_OKAY);
		pulse(6, s);
		check(s, 1'h0);
		pulse(30, s);
		check(s, 1'h1);
		check(sreq, 1'h0);
		axi_wr(CTRL_ADDR, 8'h00, RESP_OKAY);
		axi_wr(SYNC_THR_ADDR, 8'h00, RESP_OKAY);
		axi_wr(CTRL_ADDR, 8'h01, RESP_OKAY);
		pulse(4, s);
		check(s, 1'h1);
		$display("sync filter done");
	endtask
	initial
	begin
		repeat (5) @(posedge core_clk);
		reset <= 1'h0;
		t_regs;
		t_refuse;
		t_hdr;
		t_sync;
		wrap_up;
	end
endmodule // serial_link_channel_sync_config_test
